//--- rtl/ips_core.sv
// status word swap on interrupt entry and return, reset modes, wait patrol
// assumes exc_* and lsw_* come from the pipeline on clk; io_req is async
// Functional notes
// - length code in bits 32-33: 0 done, 1/2/3 for 2/4/6 bytes
// - mc, program and svc entries save the next instruction address
// - nonzero pending length code sets check bit; zero means completed
// - svc entry saves length code 1 with next address
// - tabler request accepted only while status word io mask is 1
// - tabler entry starts only at an instruction boundary
// - tabler entry saves status word with interrupt code forced zero
// - new key picks relocation table entry for active relocation
// - hardware mc or program mask set at end of that entry
// - after entry, re-examine pending requests before running
// - return copies old slot to status word and reloads relocation
// - disallowed requests are latched as pending
// - selector: 0000 clear, xx01 normal, xx10 recovery, xx11 auto
// - any reset with a valid selector accepted in any state and clears check stop
// - system and normal load resets save status, snap and relocation
// - normal load reset copies low fixed storage elsewhere first
// - system/cpu/power stop, loads continue to loading, all but cpu reset io
// - status word cleared; clear load sets io mask, normal sets mc
// - registers zeroed only by clear load; storage by clear, power
// - every reset inits controls, zeroes relocation and pendings
// - wait state self-checks and starts machine check on error
// - taking an interrupt ends the wait state
module ips_core
    import ips_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic instr_done,
    input wire logic [ADDR_W-1:0] instr_next,
    input wire logic exc_mc,
    input wire logic exc_px,
    input wire logic exc_svc,
    input wire logic [CODE_W-1:0] exc_code,
    input wire logic [1:0] exc_ilc,
    input wire logic [ADDR_W-1:0] exc_next,
    input wire logic io_req,
    input wire logic lsw_exec,
    input wire logic [1:0] lsw_level,
    input wire logic [RL_W-1:0] snap_word,
    input wire logic load_done,
    output logic [SW_W-1:0] status_word,
    output logic [RL_W-1:0] act_reloc,
    output logic running,
    output logic waiting,
    output logic check_stop,
    output logic hw_mc_mask,
    output logic hw_px_mask,
    output logic io_ack,
    output logic io_sys_reset,
    output logic store_clear,
    output logic gpr_clear,
    output logic gpr_regen,
    output logic ctl_init,
    output logic timer_stop,
    output logic low_copy,
    output logic load_start
);
    typedef struct packed {
        ips_st_t st;
        logic [SW_W-1:0] sw;
        logic sw_par;
        logic [RL_W-1:0] act_rel;
        logic hw_mc;
        logic hw_px;
        logic cstop;
        logic ret;
        logic [1:0] lvl;
        logic [NLVL-1:0] pend;
        logic [NLVL-1:0][CODE_W-1:0] pcode;
        logic [NLVL-1:0][1:0] pilc;
        logic [NLVL-1:0][SW_W-1:0] old_s;
        logic [NLVL-1:0][SW_W-1:0] new_s;
        logic [(1<<KEY_W)-1:0][RL_W-1:0] rel_tbl;
        logic [SW_W-1:0] sv_sw;
        logic [RL_W-1:0] sv_snap;
        logic [RL_W-1:0] sv_rel;
        logic [1:0] rk;
        logic [3:0] rsel;
        logic [7:0] idx;
        logic io_s1;
        logic io_s2;
        logic io_s3;
        logic io_ack;
        logic [7:0] pu;
        logic [31:0] rdata;
    } ips_regs_t;

    ips_regs_t q, d;
    logic bnd, t_mc, t_px, t_svc, t_io, any_t, go, go_ok;
    logic ld_clr, ld_nrm, rk_ld;
    logic [1:0] sel_lv, sp, hi;
    logic [3:0] ent;
    logic [NLVL-1:0] ev;
    logic [SW_W-1:0] osw;
    logic [CODE_W-1:0] ocode;

    // acceptance: tabler only at a boundary and under its mask
    assign bnd = (q.st != ST_RUN) | instr_done;
    assign t_mc = q.pend[LV_MC] & ~q.hw_mc;
    assign t_px = q.pend[LV_PX] & ~q.hw_px;
    assign t_svc = q.pend[LV_SVC];
    assign t_io = q.pend[LV_IO] & q.sw[SW_IOM] & bnd;
    assign any_t = t_mc | t_px | t_svc | t_io;
    assign sel_lv = t_mc ? LV_MC : t_px ? LV_PX : t_svc ? LV_SVC : LV_IO;
    // edge of the synchronised tabler line, read after the second flop
    assign ev = {q.io_s2 & ~q.io_s3, exc_svc, exc_px, exc_mc};
    // reset decode; xx00 other than 0000 is not a valid selector
    assign rk_ld = q.rk == RK_LOAD;
    assign ld_clr = rk_ld & (q.rsel == SEL_CLEAR);
    assign ld_nrm = rk_ld & (q.rsel != SEL_CLEAR);
    assign go = wr & (addr == A_CTRL) & wdata[CT_GO];
    assign go_ok = (wdata[CT_KIND+:2] != RK_LOAD)
                 | (wdata[CT_SEL+:4] == SEL_CLEAR)
                 | (wdata[CT_SEL+:2] != 2'h0);
    assign sp = q.idx[IX_SP+:2];
    assign ent = q.idx[IX_ENT+:4];
    assign hi = {1'b0, q.idx[IX_HALF]};

    // saved copy of the running word for the level being entered
    always_comb
    begin
        ocode = q.pcode[q.lvl];
        if (q.pilc[q.lvl] != ILC_DONE)
        begin
            ocode[CODE_CHK] = 1'b1;
        end
        osw = q.sw;
        osw[SW_CODE+:CODE_W] = (q.lvl == LV_IO) ? '0 : ocode;
        osw[SW_ILC+:2] = (q.lvl == LV_SVC) ? ILC_RR : q.pilc[q.lvl];
    end

    // whole next state; later assignments take precedence
    always_comb
    begin
        d = q;
        d.rdata = '0;
        d.pu = '0;
        d.io_ack = 1'b0;
        d.io_s1 = io_req;
        d.io_s2 = q.io_s1;
        d.io_s3 = q.io_s2;
        // software window onto slots, relocation table and save area
        if (wr && addr == A_IDX)
        begin
            d.idx = wdata[7:0];
        end
        if (wr && addr == A_DATA)
        begin
            case (sp)
                SP_NEW: d.new_s[ent[1:0]][RL_W*hi+:RL_W] = wdata;
                SP_OLD: d.old_s[ent[1:0]][RL_W*hi+:RL_W] = wdata;
                SP_REL: d.rel_tbl[ent] = wdata;
                default: d.sv_rel = d.sv_rel;  // save area is read only
            endcase
        end
        // status word may be set by software only while stopped
        if (wr && addr == A_SWHI && q.st == ST_STOP)
        begin
            d.sw[SW_W-1:RL_W] = wdata;
        end
        if (wr && addr == A_SWLO && q.st == ST_STOP)
        begin
            d.sw[RL_W-1:0] = wdata;
        end
        case (q.st)
            ST_STOP:
            begin
                if (wr && addr == A_CTRL && wdata[CT_RUN])
                begin
                    d.st = ST_CHECK;
                end
            end
            ST_RUN:
            begin
                if (instr_done)
                begin
                    d.sw[ADDR_W-1:0] = instr_next;
                    d.sw[SW_ILC+:2] = ILC_DONE;
                end
                if (lsw_exec)
                begin
                    d.sw = q.old_s[lsw_level];
                    d.hw_mc = q.hw_mc & (lsw_level != LV_MC);
                    d.hw_px = q.hw_px & (lsw_level != LV_PX);
                    d.ret = 1'b1;
                    d.st = ST_RELOC;
                end
                else if (any_t)
                begin
                    d.lvl = sel_lv;
                    d.st = ST_ENTRY;
                end
            end
            ST_WAIT:
            begin
                // patrol: word and relocation parity must still agree
                if (^{q.sw, q.act_rel} != q.sw_par)
                begin
                    d.pend[LV_MC] = 1'b1;
                    d.pcode[LV_MC] = CODE_PATROL;
                    d.pilc[LV_MC] = ILC_DONE;
                    d.lvl = LV_MC;
                    d.st = ST_ENTRY;
                end
                else if (any_t)
                begin
                    d.lvl = sel_lv;
                    d.st = ST_ENTRY;
                end
            end
            ST_ENTRY:
            begin
                d.old_s[q.lvl] = osw;
                d.pend[q.lvl] = 1'b0;
                d.sw = q.new_s[q.lvl];
                d.sw[SW_ILC+:2] = ILC_DONE;
                d.io_ack = q.lvl == LV_IO;
                d.ret = 1'b0;
                d.st = ST_RELOC;
            end
            ST_RELOC:
            begin
                d.act_rel = q.rel_tbl[q.sw[SW_KEY+:KEY_W]];
                if (!q.ret && q.lvl == LV_MC)
                begin
                    d.hw_mc = 1'b1;
                end
                if (!q.ret && q.lvl == LV_PX)
                begin
                    d.hw_px = 1'b1;
                end
                d.st = ST_CHECK;
            end
            ST_CHECK:
            begin
                if (any_t)
                begin
                    d.lvl = sel_lv;
                    d.st = ST_ENTRY;
                end
                else
                begin
                    d.st = q.sw[SW_WAIT] ? ST_WAIT : ST_RUN;
                end
            end
            ST_RESET:
            begin
                d.cstop = 1'b0;
                d.pend = '0;
                d.act_rel = '0;
                d.hw_mc = 1'b0;
                d.hw_px = 1'b0;
                d.pu[PU_CTINI] = 1'b1;
                d.pu[PU_TMSTP] = 1'b1;
                if (q.rk == RK_SYS || ld_nrm)
                begin
                    d.sv_sw = q.sw;
                    d.sv_snap = snap_word;
                    d.sv_rel = q.act_rel;
                end
                d.pu[PU_LOCPY] = ld_nrm;
                d.sw = '0;
                d.sw[SW_IOM] = ld_clr;
                d.sw[SW_MCM] = ld_nrm;
                d.pu[PU_GPCLR] = ld_clr;
                d.pu[PU_REGEN] = ~ld_clr;
                d.pu[PU_STCLR] = ld_clr | (q.rk == RK_PWR);
                d.pu[PU_IORST] = q.rk != RK_CPU;
                d.pu[PU_LOAD] = rk_ld;
                d.st = rk_ld ? ST_LOAD : ST_STOP;
            end
            ST_LOAD:
            begin
                if (load_done)
                begin
                    d.st = ST_CHECK;
                end
            end
            default: d.st = ST_STOP;
        endcase
        // event latch after the entry clear, so a new one is never lost
        for (int l = 0; l < NLVL; l++)
        begin
            if (ev[l])
            begin
                if (l == int'(LV_MC) && q.pend[LV_MC] && q.hw_mc)
                begin
                    d.cstop = 1'b1;  // repeated check while masked
                end
                d.pend[l] = 1'b1;
                d.pcode[l] = (l == int'(LV_IO)) ? '0 : exc_code;
                d.pilc[l] = (l == int'(LV_IO)) ? ILC_DONE : exc_ilc;
            end
        end
        if (q.st == ST_RUN && (exc_mc | exc_px | exc_svc))
        begin
            d.sw[ADDR_W-1:0] = exc_next;
        end
        // reset request overrides whatever the unit was doing
        if (go && go_ok)
        begin
            d.rk = wdata[CT_KIND+:2];
            d.rsel = wdata[CT_SEL+:4];
            d.st = ST_RESET;
        end
        // check stop freezes the unit until a reset
        if (d.cstop && d.st != ST_RESET)
        begin
            d.st = ST_STOP;
        end
        d.sw_par = ^{d.sw, d.act_rel};
        // read data stand one cycle after the read strobe only
        if (rd)
        begin
            case (addr)
                A_STAT: d.rdata = {20'h00000, q.pend, 1'b0, q.hw_px,
                                   q.hw_mc, q.cstop, 1'b0, q.st};
                A_SWHI: d.rdata = q.sw[SW_W-1:RL_W];
                A_SWLO: d.rdata = q.sw[RL_W-1:0];
                A_IDX: d.rdata = {24'h000000, q.idx};
                A_RELOC: d.rdata = q.act_rel;
                A_DATA:
                begin
                    case (sp)
                        SP_NEW: d.rdata = q.new_s[ent[1:0]][RL_W*hi+:RL_W];
                        SP_OLD: d.rdata = q.old_s[ent[1:0]][RL_W*hi+:RL_W];
                        SP_REL: d.rdata = q.rel_tbl[ent];
                        default: d.rdata = (ent == 4'h0) ?
                            q.sv_sw[RL_W*hi+:RL_W] :
                            (ent == 4'h1) ? q.sv_snap : q.sv_rel;
                    endcase
                end
                default: d.rdata = '0;
            endcase
        end
    end

    // the whole state in one register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign status_word = q.sw;
    assign act_reloc = q.act_rel;
    assign running = q.st == ST_RUN;
    assign waiting = q.st == ST_WAIT;
    assign check_stop = q.cstop;
    assign hw_mc_mask = q.hw_mc;
    assign hw_px_mask = q.hw_px;
    assign io_ack = q.io_ack;
    assign io_sys_reset = q.pu[PU_IORST];
    assign store_clear = q.pu[PU_STCLR];
    assign gpr_clear = q.pu[PU_GPCLR];
    assign gpr_regen = q.pu[PU_REGEN];
    assign ctl_init = q.pu[PU_CTINI];
    assign timer_stop = q.pu[PU_TMSTP];
    assign low_copy = q.pu[PU_LOCPY];
    assign load_start = q.pu[PU_LOAD];

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_svc_ilc;
        q.st == ST_ENTRY && q.lvl == LV_SVC
            |=> q.old_s[LV_SVC][SW_ILC+:2] == ILC_RR;
    endproperty
    a_svc_ilc: assert property (p_svc_ilc)
        else $error("svc old slot length code is not 1");

    property p_io_code;
        q.st == ST_ENTRY && q.lvl == LV_IO
            |=> q.old_s[LV_IO][SW_CODE+:CODE_W] == '0 && io_ack;
    endproperty
    a_io_code: assert property (p_io_code)
        else $error("tabler old slot code not zero");

    property p_io_mask;
        q.st != ST_ENTRY ##1 q.st == ST_ENTRY && q.lvl == LV_IO
            |-> $past(q.sw[SW_IOM]);
    endproperty
    a_io_mask: assert property (p_io_mask)
        else $error("tabler entry with io mask clear");

    property p_chk_bit;
        q.st == ST_ENTRY && q.lvl != LV_IO && q.pilc[q.lvl] != ILC_DONE
            |=> q.old_s[$past(q.lvl)][SW_CODE+CODE_CHK];
    endproperty
    a_chk_bit: assert property (p_chk_bit)
        else $error("check bit missing for nonzero length code");

    property p_reloc;
        q.st == ST_RELOC
            |=> q.act_rel == $past(q.rel_tbl[q.sw[SW_KEY+:KEY_W]]);
    endproperty
    a_reloc: assert property (p_reloc)
        else $error("relocation not taken from key entry");

    property p_mc_mask;
        q.st == ST_ENTRY && q.lvl == LV_MC && !go |-> ##2 q.hw_mc;
    endproperty
    a_mc_mask: assert property (p_mc_mask)
        else $error("machine check mask not set after entry");

    property p_recheck;
        q.st == ST_RELOC && !go |=> q.st == ST_CHECK;
    endproperty
    a_recheck: assert property (p_recheck)
        else $error("entry did not re-examine requests");

    property p_reset_go;
        go && go_ok |=> q.st == ST_RESET ##1 !q.cstop && q.act_rel == '0;
    endproperty
    a_reset_go: assert property (p_reset_go)
        else $error("reset not accepted or check stop kept");

    property p_clr_load;
        q.st == ST_RESET && ld_clr && !go
            |=> gpr_clear && store_clear && q.sw[SW_IOM]
                && q.st == ST_LOAD;
    endproperty
    a_clr_load: assert property (p_clr_load)
        else $error("clear load reset actions wrong");

    property p_wait_end;
        q.st == ST_WAIT && any_t && !go |=> q.st == ST_ENTRY;
    endproperty
    a_wait_end: assert property (p_wait_end)
        else $error("wait not left on interrupt");
endmodule : ips_core

//--- common/ips_pkg.sv
// constants, field positions and state type of the interrupt and reset unit
// assumes a single processor clock; shared by rtl/ips_core.sv and the bench
package ips_pkg;
    localparam int SW_W = 64;
    localparam int RL_W = 32;
    localparam int KEY_W = 4;
    localparam int NLVL = 4;
    localparam int ADDR_W = 24;
    localparam int CODE_W = 8;
    // status word fields, vector index = 63 - printed bit number
    localparam int SW_IOM = 56;  // printed bit 7, io tabler mask
    localparam int SW_MCM = 50;  // printed bit 13, machine check mask
    localparam int SW_WAIT = 49; // printed bit 14, wait mode
    localparam int SW_KEY = 52;  // printed bits 8..11, protection key
    localparam int SW_CODE = 32; // printed bits 24..31, interrupt code
    localparam int SW_ILC = 30;  // printed bits 32..33, length code
    localparam int CODE_CHK = 7; // check bit: suppressed or terminated
    localparam logic [CODE_W-1:0] CODE_PATROL = 8'h01;
    // interrupt levels, in fixed priority order
    localparam logic [1:0] LV_MC = 2'h0;
    localparam logic [1:0] LV_PX = 2'h1;
    localparam logic [1:0] LV_SVC = 2'h2;
    localparam logic [1:0] LV_IO = 2'h3;
    // length codes
    localparam logic [1:0] ILC_DONE = 2'h0;
    localparam logic [1:0] ILC_RR = 2'h1;  // 2-byte reg_reg_format
    localparam logic [1:0] ILC_RX = 2'h2;  // 4-byte indexed/immediate
    localparam logic [1:0] ILC_SS = 2'h3;  // 6-byte storage-storage
    // reset kinds and selector
    localparam logic [1:0] RK_SYS = 2'h0;
    localparam logic [1:0] RK_CPU = 2'h1;
    localparam logic [1:0] RK_LOAD = 2'h2;
    localparam logic [1:0] RK_PWR = 2'h3;
    localparam logic [3:0] SEL_CLEAR = 4'h0;
    localparam logic [1:0] SEL_NORM = 2'h1;
    // register map
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_SWHI = 8'h08;
    localparam logic [7:0] A_SWLO = 8'h0c;
    localparam logic [7:0] A_IDX = 8'h10;
    localparam logic [7:0] A_DATA = 8'h14;
    localparam logic [7:0] A_RELOC = 8'h18;
    localparam int CT_SEL = 0;
    localparam int CT_KIND = 4;
    localparam int CT_RUN = 6;
    localparam int CT_GO = 7;
    localparam int IX_HALF = 0;
    localparam int IX_ENT = 1;
    localparam int IX_SP = 5;
    localparam logic [1:0] SP_NEW = 2'h0;
    localparam logic [1:0] SP_OLD = 2'h1;
    localparam logic [1:0] SP_REL = 2'h2;
    localparam logic [1:0] SP_SAVE = 2'h3;
    // one-cycle pulse outputs
    localparam int PU_IORST = 0;
    localparam int PU_STCLR = 1;
    localparam int PU_GPCLR = 2;
    localparam int PU_REGEN = 3;
    localparam int PU_CTINI = 4;
    localparam int PU_TMSTP = 5;
    localparam int PU_LOCPY = 6;
    localparam int PU_LOAD = 7;
    typedef enum logic [2:0] {
        ST_STOP, ST_RUN, ST_WAIT, ST_ENTRY,
        ST_RELOC, ST_CHECK, ST_RESET, ST_LOAD
    } ips_st_t;
endpackage : ips_pkg

//--- tb/ips_tabler_model.sv
// tabler side model: raises a level request and holds it until taken
// assumes io_ack is a one-cycle pulse on clk from the core
module ips_tabler_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic want,
    input wire logic io_ack,
    output logic io_req
);
    timeunit 1ns;
    timeprecision 100ps;
    logic taken_q;
    // request stays up while unserved, so a masked request is not dropped
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            taken_q <= 1'b0;
            io_req <= 1'b0;
        end
        else
        begin
            taken_q <= want & (taken_q | io_ack);
            io_req <= want & ~taken_q & ~io_ack;
        end
    end
endmodule : ips_tabler_model

//--- tb/interrupt_psw_swap_and_reset_tb.sv
// bench for the status word swap and reset unit: bus tasks and scenarios
// assumes the tabler model drives io_req; other events come from here
module interrupt_psw_swap_and_reset_tb
    import ips_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, want = 1'b0;
    logic exc_mc = 1'b0, exc_svc = 1'b0, lsw_exec = 1'b0;
    logic load_done = 1'b0, clr = 1'b0, io_req, io_ack, seen_ack;
    logic [7:0] addr = 8'h00, seen, pv;
    logic [31:0] wdata = 32'h0, rdata, act_reloc, r;
    logic [CODE_W-1:0] exc_code = 8'h00;
    logic [1:0] exc_ilc = 2'h0, lsw_level = 2'h0;
    logic [ADDR_W-1:0] exc_next = 24'h0;
    logic [SW_W-1:0] status_word;
    logic running, waiting, check_stop, hw_mc_mask, hw_px_mask;
    int n_mismatch = 0, num_checks = 0;
    // reset table rows: kind, selector, pulses, end state, status high
    localparam logic [1:0] RK [9] = '{2, 0, 2, 1, 3, 2, 2, 2, 2};
    localparam logic [3:0] RS [9] = '{0, 0, 1, 0, 0, 4, 2, 3, 5};
    localparam logic [7:0] RP [9] = '{8'hb7, 8'h39, 8'hf9, 8'h38, 8'h3b,
        8'h00, 8'hf9, 8'hf9, 8'hf9};
    localparam logic [2:0] RT [9] = '{7, 0, 7, 0, 0, 0, 7, 7, 7};
    localparam logic [31:0] RH [9] = '{32'h0100_0000, 0, 32'h0004_0000,
        0, 0, 0, 32'h0004_0000, 32'h0004_0000, 32'h0004_0000};
    always #5 clk = ~clk;
    ips_core i_ips_core (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .instr_done(1'b0),
        .instr_next(24'h0), .exc_mc(exc_mc), .exc_px(1'b0),
        .exc_svc(exc_svc), .exc_code(exc_code), .exc_ilc(exc_ilc),
        .exc_next(exc_next), .io_req(io_req), .lsw_exec(lsw_exec),
        .lsw_level(lsw_level), .snap_word(32'h0), .load_done(load_done),
        .status_word(status_word), .act_reloc(act_reloc),
        .running(running), .waiting(waiting), .check_stop(check_stop),
        .hw_mc_mask(hw_mc_mask), .hw_px_mask(hw_px_mask), .io_ack(io_ack),
        .io_sys_reset(pv[0]), .store_clear(pv[1]), .gpr_clear(pv[2]),
        .gpr_regen(pv[3]), .ctl_init(pv[4]), .timer_stop(pv[5]),
        .low_copy(pv[6]), .load_start(pv[7]));
    ips_tabler_model i_ips_tabler_model (.clk(clk), .nrst(nrst),
        .want(want), .io_ack(io_ack), .io_req(io_req));
    // pulses are sticky here so their exact cycle does not matter
    always @(posedge clk)
    begin
        seen <= clr ? 8'h00 : seen | pv;
        seen_ack <= clr ? 1'b0 : seen_ack | io_ack;
    end
    task close_out;
        if (n_mismatch == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : bus_wr
    // read data stand only in the cycle after the strobe
    task bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : bus_rd
    task slot_wr(input logic [1:0] sp, input logic [3:0] e,
        input logic h, input logic [31:0] d);
        bus_wr(A_IDX, {25'h0, sp, e, h});
        bus_wr(A_DATA, d);
    endtask : slot_wr
    task slot_rd(input logic [1:0] sp, input logic [3:0] e,
        input logic h, output logic [31:0] d);
        bus_wr(A_IDX, {25'h0, sp, e, h});
        bus_rd(A_DATA, d);
    endtask : slot_rd
    task clear_seen;
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask : clear_seen
    // bounded wait; a hang counts as a mismatch
    task wait_on(input logic which);
        for (int i = 0; i < 40; i++)
        begin
            @(posedge clk);
            if ((which ? seen_ack : running) === 1'b1)
                return;
        end
        n_mismatch++;
        close_out();
    endtask : wait_on
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        close_out();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        bus_rd(A_STAT, r);
        chk(r & 32'h0000_0f3f, 32'h0);
        slot_wr(SP_NEW, LV_SVC, 1'b1, 32'h0130_005a);
        slot_wr(SP_REL, 4'h3, 1'b0, 32'hcafe_0003);
        bus_wr(A_CTRL, 32'h0000_0040);
        clear_seen();
        // tabler asks while the io mask is still zero
        want <= 1'b1;
        repeat (10) @(posedge clk);
        chk({31'h0, seen_ack}, 32'h0);
        bus_rd(A_STAT, r);
        chk(r & 32'h0000_0800, 32'h0000_0800);
        exc_ilc <= ILC_SS;
        exc_next <= 24'h00_1234;
        exc_svc <= 1'b1;
        @(posedge clk);
        exc_svc <= 1'b0;
        wait_on(1'b1);
        want <= 1'b0;
        wait_on(1'b0);
        slot_rd(SP_OLD, LV_SVC, 1'b0, r);
        chk(r & 32'hc0ff_ffff, 32'h4000_1234);
        slot_rd(SP_OLD, LV_IO, 1'b1, r);
        chk(r, 32'h0130_0000);
        // return to the level that was interrupted by the tabler entry
        lsw_level <= LV_IO;
        lsw_exec <= 1'b1;
        @(posedge clk);
        lsw_exec <= 1'b0;
        repeat (6) @(posedge clk);
        // the restored slot carries the zero code forced at tabler entry
        chk(status_word[63:32], 32'h0130_0000);
        chk(act_reloc, 32'hcafe_0003);
        exc_code <= 8'h11;
        exc_ilc <= ILC_DONE;
        exc_next <= 24'h00_abcd;
        exc_mc <= 1'b1;
        @(posedge clk);
        exc_mc <= 1'b0;
        repeat (2) @(posedge clk);
        wait_on(1'b0);
        chk({31'h0, hw_mc_mask}, 32'h1);
        slot_rd(SP_OLD, LV_MC, 1'b0, r);
        chk(r & 32'hc0ff_ffff, 32'h0000_abcd);
        slot_rd(SP_OLD, LV_MC, 1'b1, r);
        chk(r & 32'h0000_00ff, 32'h0000_0011);
        // every reset kind and selector, from run and stop states
        for (int k = 0; k < 9; k++)
        begin
            clear_seen();
            bus_wr(A_CTRL, {24'h0, 2'h2, RK[k], RS[k]});
            repeat (6) @(posedge clk);
            chk({24'h0, seen}, {24'h0, RP[k]});
            bus_rd(A_STAT, r);
            chk(r & 32'h0000_000f, {29'h0, RT[k]});
            chk(act_reloc, 32'h0);
            if (RT[k] == 3'h7)
            begin
                load_done <= 1'b1;
                @(posedge clk);
                load_done <= 1'b0;
                repeat (6) @(posedge clk);
            end
            chk(status_word[63:32], RH[k]);
        end
        close_out();
    end
endmodule : interrupt_psw_swap_and_reset_tb
